// ==== hdl/at8_pkg.sv ====
package at8_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS  = 8'h37;
  localparam logic [7:0] IDX_MASK   = 8'h70;
  localparam logic [7:0] IDX_CTRL_A = 8'hB0;
  localparam logic [7:0] IDX_CTRL_B = 8'hB1;
  localparam logic [7:0] IDX_CNT    = 8'hB2;
  localparam logic [7:0] IDX_CMP_A  = 8'hB3;
  localparam logic [7:0] IDX_CMP_B  = 8'hB4;
  localparam logic [7:0] IDX_ASYNC  = 8'hB6;

  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [4:0] RST_PEND   = 5'h00;
  localparam logic [2:0] RST_FLAGS  = 3'h0;
  localparam logic [9:0] RST_DIV    = 10'h000;

  // Flag and enable positions
  localparam int BIT_WRAP    = 0;
  localparam int BIT_MATCH_A = 1;
  localparam int BIT_MATCH_B = 2;
  // Control B fields
  localparam int BIT_FRC_A   = 7;
  localparam int BIT_FRC_B   = 6;
  localparam int BIT_WAVE_HI = 3;
  // Async status fields
  localparam int BIT_EXT_CLK = 6;
  localparam int BIT_ASYNC   = 5;
  localparam int BIT_P_CNT   = 4;
  localparam int BIT_P_CMP_A = 3;
  localparam int BIT_P_CMP_B = 2;
  localparam int BIT_P_CTL_A = 1;
  localparam int BIT_P_CTL_B = 0;
  // Control A keeps out-action fields and low wave bits only
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'h0F;

  localparam logic [7:0] MAX_COUNT = 8'hFF;
  localparam logic [7:0] BOTTOM    = 8'h00;

  // Clock select codes and divider masks
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV32   = 3'h3;
  localparam logic [2:0] CS_DIV64   = 3'h4;
  localparam logic [2:0] CS_DIV128  = 3'h5;
  localparam logic [2:0] CS_DIV256  = 3'h6;
  localparam logic [2:0] CS_DIV1024 = 3'h7;
  localparam logic [9:0] MASK_DIV1    = 10'h000;
  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV32   = 10'h01F;
  localparam logic [9:0] MASK_DIV64   = 10'h03F;
  localparam logic [9:0] MASK_DIV128  = 10'h07F;
  localparam logic [9:0] MASK_DIV256  = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

  typedef enum logic [2:0] {
    AT8_NORMAL  = 3'b000,
    AT8_PC_FF   = 3'b001,
    AT8_CTC     = 3'b010,
    AT8_FAST_FF = 3'b011,
    AT8_RSV4    = 3'b100,
    AT8_PC_A    = 3'b101,
    AT8_RSV6    = 3'b110,
    AT8_FAST_A  = 3'b111
  } at8_mode_e;
endpackage

// ==== hdl/at8_prescale.sv ====
`timescale 1ns/10ps
module at8_prescale
  import at8_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Source tick and selection
  input  wire logic       src_tick,
  input  wire logic [2:0] sel,
  // One-cycle counter step
  output logic            count_en
);
  logic [9:0] div_reg;
  logic [9:0] mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= RST_DIV;
    end else if (src_tick && (sel != CS_STOP)) begin
      div_reg <= div_reg + 10'h001;
    end
  end

  always_comb begin
    case (sel)
      CS_DIV8:    mask = MASK_DIV8;
      CS_DIV32:   mask = MASK_DIV32;
      CS_DIV64:   mask = MASK_DIV64;
      CS_DIV128:  mask = MASK_DIV128;
      CS_DIV256:  mask = MASK_DIV256;
      CS_DIV1024: mask = MASK_DIV1024;
      default:    mask = MASK_DIV1;
    endcase
  end

  // Divider is shared by all rates, so a rate change is not phase aligned
  assign count_en = src_tick && (sel != CS_STOP) &&
                    ((div_reg & mask) == mask);
endmodule

// ==== hdl/at8_timer.sv ====
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
// What this block does
// - Force bit in non-PWM mode applies a match action to that output
// - Forced match sets no flag and never clears the counter
// - Force bits are write-only strobes reading zero
// - Clock select: stop, undivided, or divide by 8..1024
// - Counter readable and writable; write blocks a match on the next tick
// - Both compare registers compared continuously, driving flags and outputs
// - Interrupt needs enable, flag and global enable all set
// - Match flags set on match, clear by ack or write one
// - Wrap flag sets on overflow or PWM bottom turn; same clearing
// - Reserved bits read zero
// - External clock enable replaces crystal; crystal runs only when zero
// - Async select picks slow oscillator pin instead of bus clock
// - Async counter write sets pending until transferred
// - Async writes to compares and controls set their pending bits
// - Counter reads live; others read their holding registers
// - Wave mode selects normal, clear-on-match, phase or fast PWM
module at8_timer
  import at8_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Slow oscillator pin
  input  wire logic        slow_osc_in_pin,
  output logic             crystal_osc_run,
  output logic             ext_clock_buffer_on,
  // Interrupt side
  input  wire logic        global_irq_enable,
  input  wire logic        ack_match_a,
  input  wire logic        ack_match_b,
  input  wire logic        ack_wrap,
  output logic             irq_match_a,
  output logic             irq_match_b,
  output logic             irq_wrap,
  // Waveform outputs
  output logic             wave_out_a,
  output logic             wave_out_b
);
  logic [7:0] idx;
  logic       mapped, acc, wr, rd_setup;
  logic       wr_flags, wr_mask, wr_ca, wr_cb, wr_cnt, wr_pa, wr_pb, wr_asy;
  logic [7:0] ctrl_a_sh, ctrl_b_sh, cmp_a_sh, cmp_b_sh, cnt_sh;
  logic [1:0] frc_sh;
  logic [7:0] ctrl_a_q, ctrl_b_q, cmp_a_q, cmp_b_q, cnt_reg, mask_reg;
  logic [4:0] pend_reg;
  logic [2:0] flag_reg;
  logic       ext_clk_reg, async_reg, block_reg, down_reg;
  logic       osc_s1, osc_s2, osc_s3, src_tick, count_en;
  logic       c_ca, c_cb, c_cnt, c_pa, c_pb;
  logic [7:0] top, cnt_next;
  logic       fast, pc, at_top, bottom_ev, wrap_ev;
  logic       match_a_ev, match_b_ev, frc_a_ev, frc_b_ev;
  logic [2:0] set_f, clr_f;
  logic [7:0] rd_mux;
  at8_mode_e  mode;

  // Bus decode; zero-wait slave with read data staged in setup
  assign idx      = paddr[9:2];
  assign acc      = psel && penable;
  assign wr       = acc && pwrite && mapped;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = acc && !mapped;
  assign wr_flags = wr && (idx == IDX_FLAGS);
  assign wr_mask  = wr && (idx == IDX_MASK);
  assign wr_ca    = wr && (idx == IDX_CTRL_A);
  assign wr_cb    = wr && (idx == IDX_CTRL_B);
  assign wr_cnt   = wr && (idx == IDX_CNT);
  assign wr_pa    = wr && (idx == IDX_CMP_A);
  assign wr_pb    = wr && (idx == IDX_CMP_B);
  assign wr_asy   = wr && (idx == IDX_ASYNC);

  always_comb begin
    mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    case (idx)
      IDX_FLAGS, IDX_MASK, IDX_CTRL_A, IDX_CTRL_B, IDX_CNT,
      IDX_CMP_A, IDX_CMP_B, IDX_ASYNC: mapped = mapped;
      default: mapped = 1'b0;
    endcase
  end

  // Slow pin sampled twice, edge taken from the settled copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= slow_osc_in_pin;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  assign src_tick            = async_reg ? (osc_s2 && !osc_s3) : 1'b1;
  assign crystal_osc_run     = async_reg && !ext_clk_reg;
  assign ext_clock_buffer_on = async_reg && ext_clk_reg;

  // Sync mode commits at once; async waits for a source tick
  assign c_ca  = async_reg ? (pend_reg[BIT_P_CTL_A] && src_tick) : wr_ca;
  assign c_cb  = async_reg ? (pend_reg[BIT_P_CTL_B] && src_tick) : wr_cb;
  assign c_cnt = async_reg ? (pend_reg[BIT_P_CNT] && src_tick) : wr_cnt;
  assign c_pa  = async_reg ? (pend_reg[BIT_P_CMP_A] && src_tick) : wr_pa;
  assign c_pb  = async_reg ? (pend_reg[BIT_P_CMP_B] && src_tick) : wr_pb;

  // Holding registers, read back for everything but the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_sh <= RST_BYTE;
      ctrl_b_sh <= RST_BYTE;
      cmp_a_sh  <= RST_BYTE;
      cmp_b_sh  <= RST_BYTE;
      cnt_sh    <= RST_BYTE;
      frc_sh    <= 2'h0;
    end else begin
      if (wr_ca) ctrl_a_sh <= pwdata[7:0] & CTRL_A_MASK;
      if (wr_cb) ctrl_b_sh <= pwdata[7:0] & CTRL_B_MASK;
      if (wr_cb) frc_sh <= {pwdata[BIT_FRC_A], pwdata[BIT_FRC_B]};
      else if (c_cb) frc_sh <= 2'h0;
      if (wr_pa) cmp_a_sh <= pwdata[7:0];
      if (wr_pb) cmp_b_sh <= pwdata[7:0];
      if (wr_cnt) cnt_sh <= pwdata[7:0];
    end
  end

  // Pending bits: a new write wins over the transfer clearing it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= RST_PEND;
    end else if (!async_reg) begin
      pend_reg <= RST_PEND;
    end else begin
      pend_reg[BIT_P_CNT]   <= wr_cnt || (pend_reg[BIT_P_CNT] && !c_cnt);
      pend_reg[BIT_P_CMP_A] <= wr_pa || (pend_reg[BIT_P_CMP_A] && !c_pa);
      pend_reg[BIT_P_CMP_B] <= wr_pb || (pend_reg[BIT_P_CMP_B] && !c_pb);
      pend_reg[BIT_P_CTL_A] <= wr_ca || (pend_reg[BIT_P_CTL_A] && !c_ca);
      pend_reg[BIT_P_CTL_B] <= wr_cb || (pend_reg[BIT_P_CTL_B] && !c_cb);
    end
  end

  // Active copies used by the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_q <= RST_BYTE;
      ctrl_b_q <= RST_BYTE;
      cmp_a_q  <= RST_BYTE;
      cmp_b_q  <= RST_BYTE;
    end else begin
      if (c_ca) ctrl_a_q <= async_reg ? ctrl_a_sh : pwdata[7:0] & CTRL_A_MASK;
      if (c_cb) ctrl_b_q <= async_reg ? ctrl_b_sh : pwdata[7:0] & CTRL_B_MASK;
      if (c_pa) cmp_a_q <= async_reg ? cmp_a_sh : pwdata[7:0];
      if (c_pb) cmp_b_q <= async_reg ? cmp_b_sh : pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg    <= RST_BYTE;
      ext_clk_reg <= 1'b0;
      async_reg   <= 1'b0;
    end else begin
      if (wr_mask) mask_reg <= pwdata[7:0] & 8'h07;
      if (wr_asy) ext_clk_reg <= pwdata[BIT_EXT_CLK];
      if (wr_asy) async_reg <= pwdata[BIT_ASYNC];
    end
  end

  at8_prescale u_prescale (
    .pclk     (pclk),
    .presetn  (presetn),
    .src_tick (src_tick),
    .sel      (ctrl_b_q[2:0]),
    .count_en (count_en)
  );

  // Mode decode; reserved modes count as normal
  assign mode = at8_mode_e'({ctrl_b_q[BIT_WAVE_HI], ctrl_a_q[1:0]});
  assign fast = (mode == AT8_FAST_FF) || (mode == AT8_FAST_A);
  assign pc   = (mode == AT8_PC_FF) || (mode == AT8_PC_A);
  assign top  = ((mode == AT8_CTC) || (mode == AT8_PC_A) ||
                 (mode == AT8_FAST_A)) ? cmp_a_q : MAX_COUNT;
  assign at_top = (cnt_reg == top);

  always_comb begin
    cnt_next = cnt_reg + 8'h01;
    if (pc && (down_reg ? (cnt_reg != BOTTOM) : at_top)) begin
      cnt_next = cnt_reg - 8'h01;
    end else if (!pc && at_top) begin
      cnt_next = BOTTOM;
    end
  end

  // A committed counter load replaces the step of that tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg   <= RST_BYTE;
      down_reg  <= 1'b0;
      block_reg <= 1'b0;
    end else begin
      if (c_cnt) begin
        cnt_reg <= async_reg ? cnt_sh : pwdata[7:0];
      end else if (count_en) begin
        cnt_reg <= cnt_next;
      end
      if (!pc) begin
        down_reg <= 1'b0;
      end else if (count_en && !c_cnt) begin
        if (at_top && !down_reg) down_reg <= 1'b1;
        else if ((cnt_reg == BOTTOM) && down_reg) down_reg <= 1'b0;
      end
      if (c_cnt) block_reg <= 1'b1;
      else if (count_en) block_reg <= 1'b0;
    end
  end

  // Events of the current tick
  assign bottom_ev  = count_en && !c_cnt && !pc && at_top;
  assign wrap_ev    = count_en && !c_cnt &&
                      (pc ? (down_reg && (cnt_reg == BOTTOM)) :
                       (mode == AT8_FAST_A) ? at_top :
                       (cnt_reg == MAX_COUNT));
  assign match_a_ev = count_en && !c_cnt && !block_reg &&
                      (cnt_reg == cmp_a_q);
  assign match_b_ev = count_en && !c_cnt && !block_reg &&
                      (cnt_reg == cmp_b_q);
  // Force is judged by the mode in effect when control B commits
  assign frc_a_ev   = c_cb && !fast && !pc &&
                      (async_reg ? frc_sh[1] : pwdata[BIT_FRC_A]);
  assign frc_b_ev   = c_cb && !fast && !pc &&
                      (async_reg ? frc_sh[0] : pwdata[BIT_FRC_B]);

  function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                     input logic m, input logic bot,
                                     input logic dn, input logic tog_ok,
                                     input logic is_fast, input logic is_pc);
    logic r;
    r = cur;
    if (!is_fast && !is_pc) begin
      if (m) r = (com == 2'h1) ? !cur : (com == 2'h2) ? 1'b0 :
                 (com == 2'h3) ? 1'b1 : cur;
    end else if (m && (com == 2'h1) && tog_ok) begin
      r = !cur;
    end else if (m && com[1]) begin
      r = is_pc ? (dn ^ !com[0]) : com[0];
    end else if (bot && com[1] && is_fast) begin
      r = !com[0];
    end
    return r;
  endfunction

  // Waveform pins; force bypasses flags and counter clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      wave_out_a <= wave_next(wave_out_a, ctrl_a_q[7:6],
                              match_a_ev || frc_a_ev, bottom_ev, down_reg,
                              ctrl_b_q[BIT_WAVE_HI], fast, pc);
      wave_out_b <= wave_next(wave_out_b, ctrl_a_q[5:4],
                              match_b_ev || frc_b_ev, bottom_ev, down_reg,
                              1'b0, fast, pc);
    end
  end

  // Flags: set wins over clear; writing zero keeps the bit
  assign set_f = {match_b_ev, match_a_ev, wrap_ev};
  assign clr_f = ({3{wr_flags}} & pwdata[2:0]) |
                 {ack_match_b, ack_match_a, ack_wrap};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= RST_FLAGS;
    end else begin
      flag_reg <= (flag_reg & ~clr_f) | set_f;
    end
  end

  assign irq_match_a = mask_reg[BIT_MATCH_A] && flag_reg[BIT_MATCH_A] &&
                       global_irq_enable;
  assign irq_match_b = mask_reg[BIT_MATCH_B] && flag_reg[BIT_MATCH_B] &&
                       global_irq_enable;
  assign irq_wrap    = mask_reg[BIT_WRAP] && flag_reg[BIT_WRAP] &&
                       global_irq_enable;

  always_comb begin
    case (idx)
      IDX_FLAGS:  rd_mux = {5'h00, flag_reg};
      IDX_MASK:   rd_mux = mask_reg;
      IDX_CTRL_A: rd_mux = ctrl_a_sh;
      IDX_CTRL_B: rd_mux = ctrl_b_sh;
      IDX_CNT:    rd_mux = cnt_reg;
      IDX_CMP_A:  rd_mux = cmp_a_sh;
      IDX_CMP_B:  rd_mux = cmp_b_sh;
      IDX_ASYNC:  rd_mux = {1'b0, ext_clk_reg, async_reg, pend_reg};
      default:    rd_mux = RST_BYTE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= mapped ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end

  property p_frc_read_zero;
    @(posedge pclk) disable iff (!presetn)
      (acc && !pwrite && mapped && idx == IDX_CTRL_B) |-> prdata[7:4] == 4'h0;
  endproperty
  a_frc_read_zero: assert property (p_frc_read_zero)
    else $error("control B read shows force or reserved bits");

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
      irq_match_a == (mask_reg[1] && flag_reg[1] && global_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("match A request not gated by enable and flag");

  property p_match_sets;
    @(posedge pclk) disable iff (!presetn)
      match_b_ev |=> flag_reg[BIT_MATCH_B];
  endproperty
  a_match_sets: assert property (p_match_sets)
    else $error("match B did not set its flag");

  property p_zero_keeps;
    @(posedge pclk) disable iff (!presetn)
      (wr_flags && !pwdata[0] && !ack_wrap && !wrap_ev) |=>
        flag_reg[BIT_WRAP] == $past(flag_reg[BIT_WRAP]);
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("writing zero changed the wrap flag");

  property p_block;
    @(posedge pclk) disable iff (!presetn)
      c_cnt ##1 count_en |-> !match_a_ev && !match_b_ev;
  endproperty
  a_block: assert property (p_block)
    else $error("match seen on the tick after a counter write");

  property p_cnt_pend;
    @(posedge pclk) disable iff (!presetn)
      (wr_cnt && async_reg && !wr_asy) |=> pend_reg[BIT_P_CNT];
  endproperty
  a_cnt_pend: assert property (p_cnt_pend)
    else $error("async counter write left pending clear");

  property p_force_quiet;
    @(posedge pclk) disable iff (!presetn)
      (frc_a_ev && !match_a_ev && !clr_f[1] && !flag_reg[1]) |=>
        !flag_reg[BIT_MATCH_A];
  endproperty
  a_force_quiet: assert property (p_force_quiet)
    else $error("forced match raised the match A flag");

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_b_q[2:0] == CS_STOP) |-> !count_en;
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter stepped with no clock selected");

  property p_wrap_sets;
    @(posedge pclk) disable iff (!presetn)
      wrap_ev |=> flag_reg[BIT_WRAP];
  endproperty
  a_wrap_sets: assert property (p_wrap_sets)
    else $error("wrap event did not set the wrap flag");

  property p_live_read;
    @(posedge pclk) disable iff (!presetn)
      (rd_setup && mapped && idx == IDX_CNT) |=>
        prdata[7:0] == $past(cnt_reg);
  endproperty
  a_live_read: assert property (p_live_read)
    else $error("counter read did not return the live value");

  property p_sync_src;
    @(posedge pclk) disable iff (!presetn)
      !async_reg |-> src_tick;
  endproperty
  a_sync_src: assert property (p_sync_src)
    else $error("sync mode lost the bus clock source");
endmodule

// ==== dv/at8_timer_tb.sv ====
`timescale 1ns/10ps
module at8_timer_tb
  import at8_pkg::*;
;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
    logic       er;
  } at8_row_s;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slow_osc_in_pin;
  logic        crystal_osc_run;
  logic        ext_clock_buffer_on;
  logic        global_irq_enable;
  logic [2:0]  ack_v;
  logic [2:0]  irq_v;
  logic        wave_out_a;
  logic        wave_out_b;
  logic        osc_on;
  logic [2:0]  osc_div = 3'h0;
  logic [7:0]  rd;
  logic        er;
  int          err_total;
  int          cmp_count;
  int          i;
  int          n;
  int          dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  logic [7:0]  regs [8] = '{IDX_FLAGS, IDX_MASK, IDX_CTRL_A, IDX_CTRL_B,
                            IDX_CNT, IDX_CMP_A, IDX_CMP_B, IDX_ASYNC};
  at8_row_s    rows [14] = '{
    '{IDX_MASK, 8'hFF, 8'h07, 1'b0}, '{IDX_MASK, 8'h00, 8'h00, 1'b0},
    '{IDX_CTRL_A, 8'hFF, 8'hF3, 1'b0}, '{IDX_CTRL_A, 8'h00, 8'h00, 1'b0},
    '{IDX_CTRL_B, 8'h38, 8'h08, 1'b0}, '{IDX_CTRL_B, 8'h00, 8'h00, 1'b0},
    '{IDX_CNT, 8'h3C, 8'h3C, 1'b0}, '{IDX_CNT, 8'h00, 8'h00, 1'b0},
    '{IDX_CMP_A, 8'h5A, 8'h5A, 1'b0}, '{IDX_CMP_B, 8'hA5, 8'hA5, 1'b0},
    '{IDX_FLAGS, 8'hF8, 8'h00, 1'b0}, '{IDX_ASYNC, 8'h80, 8'h00, 1'b0},
    '{8'h01, 8'hFF, 8'h00, 1'b1}, '{8'h40, 8'h12, 8'h00, 1'b1}};

  at8_timer dut (
    .pclk                (pclk),
    .presetn             (presetn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .slow_osc_in_pin     (slow_osc_in_pin),
    .crystal_osc_run     (crystal_osc_run),
    .ext_clock_buffer_on (ext_clock_buffer_on),
    .global_irq_enable   (global_irq_enable),
    .ack_match_a         (ack_v[1]),
    .ack_match_b         (ack_v[2]),
    .ack_wrap            (ack_v[0]),
    .irq_match_a         (irq_v[1]),
    .irq_match_b         (irq_v[2]),
    .irq_wrap            (irq_v[0]),
    .wave_out_a          (wave_out_a),
    .wave_out_b          (wave_out_b)
  );

  always #50 pclk = ~pclk;

  // Slow source held still unless a test wants ticks; period is 8 pclk
  always @(posedge pclk) begin
    if (osc_on) begin
      osc_div <= osc_div + 3'h1;
    end
    slow_osc_in_pin <= osc_div[2];
  end

  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic limit(input int cnt, input int lim);
    if (cnt >= lim) begin
      err_total++;
      $display("Error wait limit %0d used up", lim);
      summarize();
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge pclk);
      k++;
    end
    limit(k, 20);
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle;
    int k;
    for (k = 0; k < 40; k++) begin
      apb(1'b0, IDX_ASYNC, 8'h00);
      if ((rd & 8'h1F) == 8'h00) break;
    end
    limit(k, 40);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    global_irq_enable = 1'b0;
    ack_v = 3'h0;
    osc_on = 1'b0;
    err_total = 0;
    cmp_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("irq at reset", irq_v, 3'h0);
    chk("waves at reset", {wave_out_a, wave_out_b}, 2'h0);
    foreach (regs[j]) begin
      apb(1'b0, regs[j], 8'h00);
      chk("reset value", rd, 8'h00);
    end
    foreach (rows[j]) begin
      apb(1'b1, rows[j].idx, rows[j].wd);
      chk("write error", er, rows[j].er);
      apb(1'b0, rows[j].idx, 8'h00);
      chk("read back", rd, rows[j].exp);
      chk("read error", er, rows[j].er);
    end
    // Force strobes only while a non-PWM mode is set
    apb(1'b1, IDX_CTRL_A, 8'hF0);
    apb(1'b1, IDX_CTRL_B, 8'hC0);
    repeat (2) @(posedge pclk);
    chk("forced set", {wave_out_a, wave_out_b}, 2'h3);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("forced flags", rd, 8'h00);
    apb(1'b0, IDX_CNT, 8'h00);
    chk("forced count", rd, 8'h00);
    apb(1'b0, IDX_CTRL_B, 8'h00);
    chk("force reads zero", rd, 8'h00);
    apb(1'b1, IDX_CTRL_A, 8'h50);
    apb(1'b1, IDX_CTRL_B, 8'hC0);
    repeat (2) @(posedge pclk);
    chk("forced toggle", {wave_out_a, wave_out_b}, 2'h0);
    apb(1'b1, IDX_CTRL_A, 8'h00);
    apb(1'b1, IDX_CMP_A, 8'h03);
    apb(1'b1, IDX_CMP_B, 8'h80);
    apb(1'b1, IDX_CNT, 8'h00);
    apb(1'b1, IDX_MASK, 8'h07);
    global_irq_enable <= 1'b1;
    apb(1'b1, IDX_CTRL_B, 8'h01);
    for (i = 0; i < 3; i++) begin
      for (n = 0; n < 600 && irq_v[i] !== 1'b1; n++) @(posedge pclk);
      limit(n, 600);
      apb(1'b1, IDX_FLAGS, 8'h00);
      apb(1'b0, IDX_FLAGS, 8'h00);
      chk("flag kept", rd & (8'h01 << i), 8'h01 << i);
      global_irq_enable <= 1'b0;
      @(posedge pclk);
      chk("irq global off", irq_v[i], 1'b0);
      global_irq_enable <= 1'b1;
      ack_v <= 3'h1 << i;
      @(posedge pclk);
      ack_v <= 3'h0;
      @(posedge pclk);
      chk("irq after ack", irq_v[i], 1'b0);
    end
    for (n = 0; n < 600 && irq_v[1] !== 1'b1; n++) @(posedge pclk);
    limit(n, 600);
    apb(1'b1, IDX_FLAGS, 8'h02);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("write one clears", rd & 8'h02, 8'h00);
    // Counter rewritten while running, onto the compare A value
    apb(1'b1, IDX_CTRL_B, 8'h00);
    apb(1'b1, IDX_MASK, 8'h00);
    apb(1'b1, IDX_CMP_A, 8'h05);
    apb(1'b1, IDX_CNT, 8'h80);
    apb(1'b1, IDX_CTRL_B, 8'h01);
    apb(1'b1, IDX_FLAGS, 8'h07);
    apb(1'b1, IDX_CNT, 8'h05);
    repeat (4) @(posedge pclk);
    apb(1'b1, IDX_CTRL_B, 8'h00);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("match blocked", rd & 8'h02, 8'h00);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, IDX_CNT, 8'h00);
      apb(1'b1, IDX_CTRL_B, i[7:0]);
      repeat ((dv[i] == 0) ? 20 : 4 * dv[i] - 3) @(posedge pclk);
      apb(1'b1, IDX_CTRL_B, 8'h00);
      apb(1'b0, IDX_CNT, 8'h00);
      n = (dv[i] == 0) ? 0 : 4;
      chk("prescale", rd >= n - (n > 0) && rd <= n + (n > 0), 1'b1);
    end
    apb(1'b1, IDX_ASYNC, 8'h40);
    apb(1'b1, IDX_ASYNC, 8'h60);
    @(posedge pclk);
    chk("ext buffer", {crystal_osc_run, ext_clock_buffer_on}, 2'h1);
    apb(1'b1, IDX_CNT, 8'h11);
    apb(1'b1, IDX_CMP_A, 8'h22);
    apb(1'b1, IDX_CMP_B, 8'h33);
    apb(1'b1, IDX_CTRL_A, 8'h02);
    apb(1'b1, IDX_CTRL_B, 8'h00);
    apb(1'b0, IDX_ASYNC, 8'h00);
    chk("all pending", rd, 8'h7F);
    apb(1'b0, IDX_CMP_A, 8'h00);
    chk("holding read", rd, 8'h22);
    osc_on <= 1'b1;
    wait_idle();
    apb(1'b0, IDX_CNT, 8'h00);
    chk("async counter", rd, 8'h11);
    apb(1'b1, IDX_CTRL_A, 8'h00);
    wait_idle();
    apb(1'b1, IDX_CNT, 8'h00);
    wait_idle();
    apb(1'b1, IDX_CTRL_B, 8'h01);
    repeat (64) @(posedge pclk);
    apb(1'b1, IDX_CTRL_B, 8'h00);
    wait_idle();
    apb(1'b0, IDX_CNT, 8'h00);
    chk("slow clocking", rd >= 8'h04 && rd <= 8'h0A, 1'b1);
    apb(1'b1, IDX_ASYNC, 8'h20);
    @(posedge pclk);
    chk("crystal on", {crystal_osc_run, ext_clock_buffer_on}, 2'h2);
    apb(1'b1, IDX_ASYNC, 8'h00);
    @(posedge pclk);
    chk("sync source", {crystal_osc_run, ext_clock_buffer_on}, 2'h0);
    summarize();
  end
endmodule
